// File: logic/nbh_host.sv
// Host controller that drives the NAND asynchronous bus pins.
// How it works
// RULE1: Command cycle raises cmd latch with addr latch low, strobe rises.
// RULE2: Address cycle raises addr latch with cmd latch low, strobe rises.
// RULE3: Data write cycle keeps both latches low and pulses write strobe.
// RULE4: Device ignores data input when unselected or busy; host waits ready.
// RULE5: Data read cycle pulses read strobe low with latches low.
// RULE6: Data output valid only when ready after array read; host waits ready.
// RULE7: Capture read data on rising edge when cycle at least 30ns.
// RULE8: Busy die discards most commands but accepts status read 70h.
// RULE9: Upper byte driven zero during command cycles on x16.
// RULE10: Upper byte held low during address cycles on x16.
// RULE11: x8 address four cycles: column low, column high, page/block, block.
// RULE12: x8 column bit 11 set forces column bits 10..6 zero; the host zeroes only bits 10..8, in the column high cycle.
// RULE13: x16 second cycle carries column 10..8; bit 10 forces 9..5 zero; the host zeroes only bits 9..8.
// RULE14: Bits outside the address space driven low; cycle count per command.
// RULE15: Device standby while chip select high.
// RULE16: Device keeps busy operation while chip select high.
// RULE17: Transaction is command, address cycles, then data cycles.
// RULE18: Device blocks program and erase while write protect low.
// RULE19: Write protect changes only while idle and ready.
// RULE20: Wait settle time after write protect change before next command.
// RULE21: Device honours write protect always, even deselected.
// RULE22: Data and cache registers act as one in normal page operations.
// RULE23: Ready/busy high when all dies ready, low when any busy.
// RULE24: First command after power-on is reset FFh; busy follows.
// RULE25: Device column pointer advances per data word.
`timescale 1ns/1ps
module nbh_host
   import nbh_pkg::*;
#(
   parameter int BUS_W = 8
)
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [1:0] req_kind,
   input wire logic [15:0] req_data,
   input wire logic req_wait_ready,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic wp_req,
   output logic [BUS_W-1:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic busy,
   output logic chip_select_n,
   output logic cmd_latch_en,
   output logic addr_latch_en,
   output logic write_strobe_n,
   output logic read_strobe_n,
   output logic write_protect_n,
   output logic [BUS_W-1:0] io_out,
   output logic io_oe,
   input wire logic [BUS_W-1:0] io_in,
   input wire logic ready_busy_n
);
   initial
   begin
      if (BUS_W != 8 && BUS_W != 16)
         $error("nbh_host bus width must be 8 or 16");
   end
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_LOW = 3'h1,
      ST_HIGH = 3'h2,
      ST_WAIT = 3'h3,
      ST_WP = 3'h4
   } nbh_state_t;
   // Synchronisers for the asynchronous pin inputs.
   logic [BUS_W-1:0] io_s1;
   logic [BUS_W-1:0] io_s2;
   logic rb_s1;
   logic rb_s2;
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         io_s1 <= '0;
         io_s2 <= '0;
         rb_s1 <= 1'b0;
         rb_s2 <= 1'b0;
      end
      else
      begin
         io_s1 <= io_in;
         io_s2 <= io_s1;
         rb_s1 <= ready_busy_n;
         rb_s2 <= rb_s1;
      end
   end
   nbh_state_t state;
   nbh_state_t next_state;
   logic [1:0] kind;
   logic [1:0] next_kind;
   logic [15:0] word;
   logic [15:0] next_word;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic wp;
   logic next_wp;
   logic wp_done;
   logic next_wp_done;
   logic cap_valid;
   logic [BUS_W-1:0] cap_data;
   logic fifo_ready;
   logic wait_rdy;
   logic next_wait_rdy;
   logic cap_pend, next_cap_pend;
   logic [1:0] acnt, next_acnt;
   logic sec_cyc, next_sec_cyc;
   logic reset_seen, next_reset_seen;
   // Upper byte zero for command and address; the column high cycle keeps only valid bits.
   function automatic logic [BUS_W-1:0] bus_word(input logic [1:0] k, input logic [15:0] w,
      input logic sec);
      logic [15:0] v;
      v = (k == KIND_CMD || k == KIND_ADDR) ? {8'h00, w[7:0]} : w; // RULE9 RULE10 RULE14
      if (k == KIND_ADDR && sec) // RULE11 RULE12 RULE13
         v = (BUS_W == 8) ? (w[3] ? 16'h0008 : {12'h000, w[3:0]})
            : (w[2] ? 16'h0004 : {13'h0000, w[2:0]});
      return v[BUS_W-1:0];
   endfunction : bus_word
   always_comb
   begin
      next_state = state;
      next_kind = kind;
      next_word = word;
      next_cnt = cnt;
      next_wp = wp;
      next_wp_done = 1'b0;
      next_wait_rdy = wait_rdy;
      next_cap_pend = 1'b0;
      next_acnt = acnt;
      next_sec_cyc = sec_cyc;
      next_reset_seen = reset_seen;
      req_ready = 1'b0;
      case (state)
         ST_IDLE:
         begin
            // Write protect moves only between bus cycles (ST_IDLE), device ready.
            if (wp_req != wp && rb_s2) // RULE19
            begin
               next_wp = wp_req;
               next_cnt = CNT_W'(WP_SETTLE_CYC);
               next_state = ST_WP;
            end
            else if (req_valid && (!req_wait_ready || rb_s2) // RULE4 RULE6 RULE17
               && (reset_seen || (req_kind == KIND_CMD && req_data[7:0] == CMD_RESET))) // RULE24
            begin
               req_ready = (req_kind != KIND_READ) || (fifo_ready && !cap_pend);
               if (req_ready)
               begin
                  next_reset_seen = 1'b1;
                  next_sec_cyc = (req_kind == KIND_ADDR) && acnt == 2'h1; // RULE11
                  next_acnt = (req_kind == KIND_CMD) ? 2'h0
                     : acnt + {1'b0, req_kind == KIND_ADDR && acnt != 2'h3};
                  next_kind = req_kind;
                  next_word = req_data;
                  next_wait_rdy = req_wait_ready;
                  next_cnt = CNT_W'(STROBE_LOW_CYC);
                  next_state = ST_LOW;
               end
            end
         end
         ST_LOW:
         begin
            if (cnt > CNT_W'(1))
               next_cnt = cnt - 1'b1;
            else
            begin
               next_cnt = CNT_W'(STROBE_HIGH_CYC);
               next_state = ST_HIGH;
            end
         end
         ST_HIGH:
         begin
            if (cnt == CNT_W'(STROBE_HIGH_CYC) && kind == KIND_READ)
               next_cap_pend = 1'b1; // RULE7
            if (cnt > CNT_W'(1))
               next_cnt = cnt - 1'b1;
            else
               next_state = ST_IDLE;
         end
         ST_WP:
         begin
            if (cnt > CNT_W'(1)) // RULE20
               next_cnt = cnt - 1'b1;
            else
            begin
               next_wp_done = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default:
            next_state = ST_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= ST_IDLE;
         kind <= KIND_CMD;
         word <= '0;
         cnt <= '0;
         wp <= 1'b0;
         wp_done <= 1'b0;
         wait_rdy <= 1'b0;
         cap_pend <= 1'b0;
         acnt <= 2'h0;
         sec_cyc <= 1'b0;
         reset_seen <= 1'b0;
      end
      else
      begin
         state <= next_state;
         kind <= next_kind;
         word <= next_word;
         cnt <= next_cnt;
         wp <= next_wp;
         wp_done <= next_wp_done;
         wait_rdy <= next_wait_rdy;
         cap_pend <= next_cap_pend;
         acnt <= next_acnt;
         sec_cyc <= next_sec_cyc;
         reset_seen <= next_reset_seen;
      end
   end
   // Data seen at the strobe rise leaves the synchroniser a cycle later, so the push waits.
   assign cap_data = io_s2;
   assign cap_valid = cap_pend;
   nbh_fifo #(
      .WIDTH(BUS_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .in_data(cap_data),
      .in_valid(cap_valid),
      .in_ready(fifo_ready),
      .out_data(rd_data),
      .out_valid(rd_valid),
      .out_ready(rd_ready)
   );
   always_comb
   begin
      chip_select_n = (state == ST_IDLE || state == ST_WP); // RULE15 RULE16
      cmd_latch_en = (state != ST_IDLE && state != ST_WP) && kind == KIND_CMD; // RULE1
      addr_latch_en = (state != ST_IDLE && state != ST_WP) && kind == KIND_ADDR; // RULE2
      write_strobe_n = !(state == ST_LOW && kind != KIND_READ); // RULE1 RULE2 RULE3
      read_strobe_n = !(state == ST_LOW && kind == KIND_READ); // RULE5
      io_oe = (state == ST_LOW || state == ST_HIGH) && kind != KIND_READ;
      io_out = bus_word(kind, word, sec_cyc);
      write_protect_n = wp; // RULE18 RULE21
      busy = (state != ST_IDLE) || !rb_s2; // RULE23
   end
   a_cmd_pins: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE1
      cmd_latch_en |-> !addr_latch_en && !chip_select_n && read_strobe_n)
      else $error("command cycle pins wrong");
   a_addr_pins: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE2
      addr_latch_en |-> !cmd_latch_en && read_strobe_n
         && (sec_cyc || io_out == BUS_W'(word[7:0])))
      else $error("address cycle pins wrong");
   a_col_high: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE11 RULE12 RULE13
      addr_latch_en && sec_cyc |-> io_out <= BUS_W'(BUS_W == 8 ? 8 : 4))
      else $error("column high address cycle wrong");
   a_write_low: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE3
      $fell(write_strobe_n) |=> $rose(write_strobe_n) && io_oe)
      else $error("write strobe width wrong");
   a_read_low: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE5
      !read_strobe_n |-> !cmd_latch_en && !addr_latch_en && write_strobe_n && !io_oe)
      else $error("read cycle pins wrong");
   a_read_capture: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE7
      $rose(read_strobe_n) |=> cap_valid)
      else $error("read data not captured");
   a_wp_settle: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE20
      $changed(write_protect_n) |-> chip_select_n [*4])
      else $error("command before write protect settle");
   a_wp_idle: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE19
      $changed(write_protect_n) |-> $past(state) == ST_IDLE && $past(rb_s2))
      else $error("write protect changed while not idle");
   a_wait_ready: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE4
      $fell(chip_select_n) && wait_rdy |-> $past(rb_s2))
      else $error("waited request started while busy");
   a_cmd_upper: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE9
      (cmd_latch_en || addr_latch_en) |-> io_out == BUS_W'(word[7:0]))
      else $error("upper byte not zero");
   a_first_reset: assert property (@(posedge sys_clk) disable iff (!rstn) // RULE24
      cmd_latch_en && io_out[7:0] != CMD_RESET |-> $past(reset_seen))
      else $error("command sent before reset");
   c_cmd: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(cmd_latch_en));
   c_read: cover property (@(posedge sys_clk) disable iff (!rstn) cap_valid);
   c_fifo_full: cover property (@(posedge sys_clk) disable iff (!rstn) !fifo_ready);
   c_wp: cover property (@(posedge sys_clk) disable iff (!rstn) wp_done);
endmodule : nbh_host

// File: logic/nbh_pkg.sv
// Shared constants for the NAND bus host controller.
package nbh_pkg;
   localparam int CLK_PERIOD_NS = 25;
   // Strobe low and high phase times in ns.
   localparam int STROBE_LOW_NS = 25;
   localparam int STROBE_HIGH_NS = 25;
   localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Write-protect settle time in ns.
   localparam int WP_SETTLE_NS = 100;
   localparam int WP_SETTLE_CYC = (WP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Long read cycle bound in ns; capture edge choice.
   localparam int LONG_READ_CYCLE_NS = 30;
   localparam int READ_CYCLE_NS = (STROBE_LOW_CYC + STROBE_HIGH_CYC) * CLK_PERIOD_NS;
   localparam bit CAPTURE_ON_RISE = (READ_CYCLE_NS >= LONG_READ_CYCLE_NS);
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam int CNT_W = 16;
   localparam logic [1:0] KIND_CMD = 2'h0;
   localparam logic [1:0] KIND_ADDR = 2'h1;
   localparam logic [1:0] KIND_WRITE = 2'h2;
   localparam logic [1:0] KIND_READ = 2'h3;
   localparam int FIFO_DEPTH = 4;
endpackage : nbh_pkg

// File: logic/nbh_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module nbh_fifo
   import nbh_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   initial
   begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
         $error("nbh_fifo depth must be a power of two of at least two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic [AW:0] next_wr_ptr;
   logic [AW:0] next_rd_ptr;
   logic push;
   logic pop;
   always_comb
   begin
      in_ready = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
      out_valid = wr_ptr != rd_ptr;
      out_data = mem[rd_ptr[AW-1:0]];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end
   always_ff @(posedge sys_clk)
   begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule : nbh_fifo

// File: test/nbh_device_model.sv
// Behavioural NAND die model that answers the host controller's bus cycles.
`timescale 1ns/1ps
module nbh_device_model
   import nbh_pkg::*;
#(
   parameter int BUSY_NS = 400
)
(
   input wire logic chip_select_n,
   input wire logic cmd_latch_en,
   input wire logic addr_latch_en,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic write_protect_n,
   input wire logic [7:0] io_out,
   input wire logic io_oe,
   output logic [7:0] io_in,
   output logic ready_busy_n,
   output logic [7:0] cmd_reg,
   output logic [31:0] addr_reg
);
   logic [7:0] cache [16];
   logic [3:0] col;
   logic status_mode;
   logic fail;
   logic kick;
   int acnt;
   int falls;
   int n;
   initial
   begin
      foreach (cache[i]) cache[i] = 8'h00;
      io_in = 8'h00;
      ready_busy_n = 1'b1;
      status_mode = 1'b0;
      fail = 1'b0;
      kick = 1'b0;
      falls = 0;
   end
   // Busy pulse keeps running regardless of chip select.
   always @(kick)
   begin
      ready_busy_n = 1'b0;
      #(BUSY_NS);
      ready_busy_n = 1'b1;
   end
   always @(posedge write_strobe_n)
   begin
      if (!chip_select_n && read_strobe_n && io_oe)
      begin
         if (cmd_latch_en && !addr_latch_en && (ready_busy_n || io_out == CMD_STATUS))
         begin
            cmd_reg = io_out;
            status_mode = (io_out == CMD_STATUS);
            acnt = 0;
            if (io_out == 8'h30 || io_out == CMD_RESET) kick = !kick;
            if (io_out == 8'h10) fail = !write_protect_n;
            if (io_out == 8'h10 && write_protect_n) kick = !kick;
         end
         else if (addr_latch_en && !cmd_latch_en)
         begin
            addr_reg = {io_out, addr_reg[31:8]};
            if (acnt == 0) col = io_out[3:0];
            acnt++;
         end
         else if (!addr_latch_en && !cmd_latch_en && ready_busy_n)
         begin
            cache[col] = io_out;
            col++;
         end
      end
   end
   always @(negedge read_strobe_n)
   begin
      falls++;
      if (!chip_select_n && !cmd_latch_en && !addr_latch_en && write_strobe_n)
      begin
         if (status_mode) io_in = {write_protect_n, ready_busy_n, 5'h00, fail};
         else if (ready_busy_n)
         begin
            io_in = cache[col];
            col++;
         end
      end
   end
   // Once the hold time has run out the released bus shows the inverse value.
   always @(posedge read_strobe_n)
   begin
      n = falls;
      #60;
      if (n == falls) io_in = ~io_in;
   end
endmodule : nbh_device_model

// File: test/nbh_host_bench.sv
// Self-checking bench for the NAND bus host controller.
`timescale 1ns/1ps
module nbh_host_bench
   import nbh_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] req_kind;
   logic [15:0] req_data;
   logic req_wait_ready, req_valid, req_ready, wp_req, rd_valid, rd_ready, busy;
   logic [7:0] rd_data, io_out, io_in;
   logic chip_select_n, cmd_latch_en, addr_latch_en, write_strobe_n, read_strobe_n;
   logic write_protect_n, io_oe, ready_busy_n;
   logic [7:0] cmd_reg;
   logic [31:0] addr_reg, adr;
   logic [7:0] expq [$];
   logic [7:0] wdat [4];
   int err_total, checks, seed, waited, i;
   always #12.5 sys_clk = ~sys_clk;
   nbh_host #(.BUS_W(8)) dut (.sys_clk(sys_clk), .rstn(rstn), .req_kind(req_kind),
      .req_data(req_data), .req_wait_ready(req_wait_ready), .req_valid(req_valid),
      .req_ready(req_ready), .wp_req(wp_req), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .busy(busy), .chip_select_n(chip_select_n),
      .cmd_latch_en(cmd_latch_en), .addr_latch_en(addr_latch_en),
      .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .write_protect_n(write_protect_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
      .ready_busy_n(ready_busy_n));
   nbh_device_model dm (.chip_select_n(chip_select_n), .cmd_latch_en(cmd_latch_en),
      .addr_latch_en(addr_latch_en), .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n), .io_out(io_out),
      .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n), .cmd_reg(cmd_reg),
      .addr_reg(addr_reg));
   task automatic print_verdict;
      $display("Comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic fail_out;
      err_total++;
      print_verdict();
   endtask : fail_out
   task automatic req(input logic [1:0] k, input logic [7:0] d, input logic w);
      @(posedge sys_clk);
      req_kind <= k;
      req_data <= {8'h00, d};
      req_wait_ready <= w;
      req_valid <= 1'b1;
      waited = 0;
      @(negedge sys_clk);
      while (req_ready !== 1'b1)
      begin
         waited++;
         if (waited > 300) fail_out();
         @(negedge sys_clk);
      end
      @(posedge sys_clk);
      req_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : req
   task automatic send_addr;
      req(KIND_ADDR, adr[7:0], 1'b0);
      req(KIND_ADDR, {5'h00, adr[10:8]}, 1'b0);
      req(KIND_ADDR, adr[23:16], 1'b0);
      req(KIND_ADDR, adr[31:24], 1'b0);
      check(addr_reg, {adr[31:16], 5'h00, adr[10:0]});
   endtask : send_addr
   task automatic read_one(input logic [7:0] e, input logic w);
      expq.push_back(e);
      req(KIND_READ, 8'h00, w);
   endtask : read_one
   always @(posedge sys_clk)
   begin
      if (rd_valid === 1'b1 && rd_ready === 1'b1)
      begin
         if (expq.size() == 0) fail_out();
         else check(rd_data, expq.pop_front());
      end
   end
   initial
   begin
      seed = 3;
      err_total = 0;
      checks = 0;
      req_kind = 2'h0;
      req_data = 16'h0000;
      req_wait_ready = 1'b0;
      req_valid = 1'b0;
      wp_req = 1'b0;
      rd_ready = 1'b1;
      repeat (5) @(posedge sys_clk);
      check({chip_select_n, io_oe, write_protect_n}, 3'h4);
      rstn <= 1'b1;
      req(KIND_CMD, CMD_RESET, 1'b1);
      check(cmd_reg, CMD_RESET);
      $display("Test reset command done");
      @(posedge sys_clk);
      wp_req <= 1'b1;
      req(KIND_CMD, 8'h80, 1'b1);
      check(waited >= WP_SETTLE_CYC, 1'b1);
      check(write_protect_n, 1'b1);
      adr = $random(seed);
      send_addr();
      for (i = 0; i < 4; i++)
      begin
         wdat[i] = $random(seed);
         req(KIND_WRITE, wdat[i], 1'b0);
      end
      req(KIND_CMD, 8'h10, 1'b0);
      req(KIND_CMD, CMD_STATUS, 1'b0);
      @(posedge sys_clk);
      check(busy, 1'b1);
      read_one(8'h80, 1'b0);
      $display("Test program and busy status done");
      req(KIND_CMD, 8'h00, 1'b1);
      send_addr();
      req(KIND_CMD, 8'h30, 1'b0);
      @(posedge sys_clk);
      rd_ready <= 1'b0;
      for (i = 0; i < 4; i++) read_one(wdat[i], 1'b1);
      expq.push_back(8'h00);
      @(posedge sys_clk);
      req_kind <= KIND_READ;
      req_valid <= 1'b1;
      repeat (6)
      begin
         @(negedge sys_clk);
         check(req_ready, 1'b0);
      end
      @(posedge sys_clk);
      rd_ready <= 1'b1;
      req(KIND_READ, 8'h00, 1'b1);
      $display("Test read back and buffer full done");
      @(posedge sys_clk);
      wp_req <= 1'b0;
      req(KIND_CMD, 8'h80, 1'b1);
      req(KIND_CMD, 8'h10, 1'b0);
      req(KIND_CMD, CMD_STATUS, 1'b0);
      read_one(8'h41, 1'b0);
      repeat (10) @(posedge sys_clk);
      check(expq.size(), 0);
      check(busy, 1'b0);
      $display("Test write protect done");
      print_verdict();
   end
endmodule : nbh_host_bench
